// ===== src/mm_burst_master.sv
// Burst master port that drives lane masks and burst qualifiers on the fabric
`timescale 1ns/10ps
`default_nettype none

module mm_burst_master #(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 32,
   parameter int BURST_W = 8
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [BURST_W-1:0] cmd_count,
   input wire logic [DATA_W/8-1:0] cmd_lanes,
   output logic cmd_error,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [DATA_W-1:0] wr_data,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic [ADDR_W-1:0] bus_address,
   output logic [BURST_W-1:0] bus_burstcount,
   output logic [DATA_W/8-1:0] bus_byteenable,
   output logic bus_read,
   output logic bus_write,
   output logic [DATA_W-1:0] bus_writedata,
   input wire logic bus_waitrequest,
   input wire logic [DATA_W-1:0] bus_readdata,
   input wire logic bus_readdatavalid
);
   localparam int LANES = DATA_W / lane_rules_pkg::BYTE_W;
   localparam logic [ADDR_W-1:0] LOW_MASK = ADDR_W'(LANES - 1);
   localparam logic [BURST_W-1:0] ONE_BEAT = BURST_W'(1);

   // ****************************************
   // Registers
   // ****************************************
   lane_rules_pkg::state_type state_ff, nxt_state;
   logic [ADDR_W-1:0] bus_address_ff;
   logic [BURST_W-1:0] bus_burstcount_ff;
   logic [LANES-1:0] bus_byteenable_ff;
   logic bus_read_ff, nxt_bus_read;
   logic bus_write_ff, nxt_bus_write;
   logic [DATA_W-1:0] bus_writedata_ff;
   logic [BURST_W-1:0] rem_ff, nxt_rem;
   logic cmd_ready_ff, cmd_error_ff, wr_ready_ff;
   logic [DATA_W-1:0] rd_data_ff;
   logic rd_valid_ff;

   // ****************************************
   // Decode
   // ****************************************
   wire cmd_take = cmd_valid & cmd_ready_ff;
   wire single = (cmd_count == ONE_BEAT);
   wire [LANES-1:0] req_lanes = single ? cmd_lanes : {LANES{1'b1}};
   wire lanes_legal;
   wire cmd_bad = (cmd_count == '0) | ~lanes_legal;
   wire start_rd = cmd_take & ~cmd_bad & ~cmd_write;
   wire start_wr = cmd_take & ~cmd_bad & cmd_write;
   wire in_read = (state_ff == lane_rules_pkg::ST_READ);
   wire in_write = (state_ff == lane_rules_pkg::ST_WRITE);
   wire read_accept = bus_read_ff & ~bus_waitrequest;
   wire write_accept = bus_write_ff & ~bus_waitrequest;
   wire beat_in = in_read & bus_readdatavalid;
   wire last_read = beat_in & (rem_ff == ONE_BEAT);
   wire last_write = write_accept & (rem_ff == ONE_BEAT);
   wire wr_take = wr_valid & wr_ready_ff;
   // Byte address aligned to the data word; lanes pick the bytes
   wire [ADDR_W-1:0] word_addr = cmd_addr & ~LOW_MASK;
   wire [DATA_W-1:0] lane_bits;
   wire [DATA_W-1:0] rd_masked = bus_readdata & lane_bits;

   genvar k;
   generate
      for (k = 0; k < LANES; k++) begin : g_lane
         assign lane_bits[k*8 +: 8] = {8{bus_byteenable_ff[k]}};
      end
   endgenerate

   lane_shape_check #(.LANES(LANES)) u_req_check (
      .lanes(req_lanes),
      .legal(lanes_legal)
   );

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_bus_read = bus_read_ff;
      nxt_bus_write = bus_write_ff;
      nxt_rem = rem_ff;
      case (state_ff)
         lane_rules_pkg::ST_IDLE: begin
            if (start_rd) begin
               nxt_state = lane_rules_pkg::ST_READ;
               nxt_bus_read = 1'b1;
               nxt_rem = cmd_count;
            end else if (start_wr) begin
               nxt_state = lane_rules_pkg::ST_WRITE;
               nxt_rem = cmd_count;
            end
         end
         lane_rules_pkg::ST_READ: begin
            // One read command covers the whole burst
            if (read_accept) begin
               nxt_bus_read = 1'b0;
            end
            if (beat_in) begin
               nxt_rem = rem_ff - ONE_BEAT;
            end
            if (last_read) begin
               nxt_state = lane_rules_pkg::ST_IDLE;
            end
         end
         lane_rules_pkg::ST_WRITE: begin
            // Write drops after every accepted beat and returns once the next word is taken
            if (wr_take) begin
               nxt_bus_write = 1'b1;
            end else if (write_accept) begin
               nxt_bus_write = 1'b0;
               nxt_rem = rem_ff - ONE_BEAT;
            end
            if (last_write) begin
               nxt_state = lane_rules_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = lane_rules_pkg::ST_IDLE;
            nxt_bus_read = 1'b0;
            nxt_bus_write = 1'b0;
         end
      endcase
   end

   wire nxt_idle = (nxt_state == lane_rules_pkg::ST_IDLE);
   wire nxt_wr_ready = (nxt_state == lane_rules_pkg::ST_WRITE) &
      ~nxt_bus_write;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= lane_rules_pkg::ST_IDLE;
         bus_read_ff <= lane_rules_pkg::RST_LOW;
         bus_write_ff <= lane_rules_pkg::RST_LOW;
         rem_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         bus_read_ff <= nxt_bus_read;
         bus_write_ff <= nxt_bus_write;
         rem_ff <= nxt_rem;
      end
   end

   // Qualifiers load only at burst start, never mid-burst
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_address_ff <= '0;
         bus_burstcount_ff <= '0;
         bus_byteenable_ff <= '0;
      end else if (start_rd | start_wr) begin
         bus_address_ff <= word_addr;
         bus_burstcount_ff <= cmd_count;
         bus_byteenable_ff <= req_lanes;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_writedata_ff <= '0;
      end else if (wr_take) begin
         bus_writedata_ff <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cmd_ready_ff <= lane_rules_pkg::RST_READY;
         cmd_error_ff <= lane_rules_pkg::RST_LOW;
         wr_ready_ff <= lane_rules_pkg::RST_LOW;
         rd_valid_ff <= lane_rules_pkg::RST_LOW;
         rd_data_ff <= '0;
      end else begin
         cmd_ready_ff <= nxt_idle;
         cmd_error_ff <= cmd_take & cmd_bad;
         wr_ready_ff <= nxt_wr_ready;
         rd_valid_ff <= beat_in;
         if (beat_in) begin
            rd_data_ff <= rd_masked;
         end
      end
   end

   assign cmd_ready = cmd_ready_ff;
   assign cmd_error = cmd_error_ff;
   assign wr_ready = wr_ready_ff;
   assign rd_data = rd_data_ff;
   assign rd_valid = rd_valid_ff;
   assign bus_address = bus_address_ff;
   assign bus_burstcount = bus_burstcount_ff;
   assign bus_byteenable = bus_byteenable_ff;
   assign bus_read = bus_read_ff;
   assign bus_write = bus_write_ff;
   assign bus_writedata = bus_writedata_ff;

   // ****************************************
   // Checks
   // ****************************************
   wire out_legal;
   lane_shape_check #(.LANES(LANES)) u_out_check (
      .lanes(bus_byteenable_ff),
      .legal(out_legal)
   );
   wire bus_busy = bus_read_ff | bus_write_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence read_start_s;
      cmd_take && !cmd_write && !cmd_bad;
   endsequence
   sequence read_issue_s;
      bus_read_ff && in_read;
   endsequence
   sequence burst_end_s;
      last_read || last_write;
   endsequence

   width_limit_a: assert property (
      LANES <= lane_rules_pkg::MAX_LANES &&
      DATA_W <= lane_rules_pkg::MAX_DATA_W)
      else $error("data width beyond limit");
   read_lanes_a: assert property (
      read_start_s |=> read_issue_s ##0
      (bus_byteenable_ff == $past(req_lanes)))
      else $error("read lane mask not carried");
   burst_lanes_a: assert property (
      bus_busy && bus_burstcount_ff > ONE_BEAT |->
      bus_byteenable_ff == {LANES{1'b1}})
      else $error("partial lanes in burst");
   burst_hold_a: assert property (
      !nxt_idle && !cmd_ready_ff |=>
      $stable(bus_address_ff) && $stable(bus_burstcount_ff) &&
      $stable(bus_byteenable_ff))
      else $error("qualifier changed mid-burst");
   lane_shape_a: assert property (bus_busy |-> out_legal)
      else $error("illegal lane mask on bus");
   byte_addr_a: assert property (
      bus_busy |-> (bus_address_ff & LOW_MASK) == '0)
      else $error("address not word aligned byte address");
   bad_reject_a: assert property (
      cmd_take && cmd_bad |=> cmd_error_ff && cmd_ready_ff && !bus_busy)
      else $error("bad command not rejected");
   read_drop_a: assert property (
      read_accept |=> !bus_read_ff ##0 (in_read || cmd_ready_ff))
      else $error("read held after acceptance");
   burst_end_a: assert property (
      burst_end_s |=> cmd_ready_ff && !bus_busy)
      else $error("port not idle after last beat");
endmodule : mm_burst_master

`default_nettype wire

// ===== src/lane_rules.sv
// Shared constants and the lane-mask shape checker of the burst master port
// What this block does
// - Data path up to 1024 bits, lane mask up to 128 bits, one per byte.
// - Lane mask carries meaning on reads too and the port honours it there.
// - During any master burst, every lane mask bit is driven active.
// - Address, burst count and lane mask stay fixed for the whole burst.
// - Several active lanes must form one aligned power-of-two run.
// - Master addresses are always byte addresses.
`timescale 1ns/10ps
`default_nettype none

package lane_rules_pkg;
   // ****************************************
   // Limits and reset values
   // ****************************************
   localparam int MAX_DATA_W = 1024;
   localparam int MAX_LANES = 128;
   localparam int BYTE_W = 8;
   localparam logic RST_LOW = 1'b0;
   localparam logic RST_READY = 1'b1;

   // ****************************************
   // Port sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } state_type;
endpackage : lane_rules_pkg

module lane_shape_check #(
   parameter int LANES = 4
) (
   input wire logic [LANES-1:0] lanes,
   output logic legal
);
   localparam int LOG = $clog2(LANES);

   // Heap layout: size 2**lvl has (LANES >> lvl) slots at base (LANES>>lvl)-1
   logic [2*LANES-2:0] hit;

   genvar lvl, j;
   generate
      for (lvl = 0; lvl <= LOG; lvl++) begin : g_size
         for (j = 0; j < (LANES >> lvl); j++) begin : g_off
            localparam int SZ = 1 << lvl;
            localparam logic [LANES-1:0] RUN =
               LANES'({SZ{1'b1}}) << (j * SZ);
            assign hit[(LANES >> lvl) - 1 + j] = (lanes == RUN);
         end
      end
   endgenerate

   // One aligned power-of-two run; an empty mask is never legal
   assign legal = |hit;
endmodule : lane_shape_check

`default_nettype wire

// ===== testbench/fabric_model.sv
// Fabric slave model answering the burst master port
`timescale 1ns/10ps
`default_nettype none

module fabric_model #(
   parameter int DATA_W = 32,
   parameter int BURST_W = 8
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic bus_read,
   input wire logic [BURST_W-1:0] bus_burstcount,
   input wire logic [DATA_W/8-1:0] bus_byteenable,
   output logic bus_waitrequest,
   output logic [DATA_W-1:0] bus_readdata,
   output logic bus_readdatavalid
);
   // ****************************************
   // Stall pattern and read beats
   // ****************************************
   logic tog_ff;
   logic [BURST_W-1:0] left_ff;
   logic [DATA_W-1:0] data_ff;
   wire beat_now = (left_ff != '0) && !(slow && tog_ff);
   assign bus_waitrequest = slow & ~tog_ff;
   assign bus_readdatavalid = beat_now;
   // Slave side sees every lane on throughout a burst
   wire [DATA_W/8-1:0] slave_lanes = (bus_burstcount > BURST_W'(1)) ?
      '1 : bus_byteenable;
   wire [DATA_W-1:0] slave_bits;
   genvar g;
   generate
      for (g = 0; g < DATA_W/8; g++) begin : g_lane
         assign slave_bits[g*8 +: 8] = {8{slave_lanes[g]}};
      end
   endgenerate
   // Off lanes and idle cycles carry inverted data, so stale or
   // unmasked bytes never match
   assign bus_readdata = beat_now ?
      ((data_ff & slave_bits) | (~data_ff & ~slave_bits)) : ~data_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tog_ff <= 1'b0;
         left_ff <= '0;
         data_ff <= '0;
      end else begin
         tog_ff <= ~tog_ff;
         if (bus_read && !bus_waitrequest) begin
            left_ff <= bus_burstcount;
            data_ff <= DATA_W'(32'h11223344);
         end else if (beat_now) begin
            left_ff <= left_ff - BURST_W'(1);
            data_ff <= data_ff + 32'h01010101;
         end
      end
   end
endmodule : fabric_model
`default_nettype wire

// ===== testbench/mm_burst_master_tb.sv
// Self-checking bench of the burst master port
`timescale 1ns/10ps
`default_nettype none

module mm_burst_master_tb;
   logic clock = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
   logic wr_valid = 1'b0, slow = 1'b0;
   logic [31:0] cmd_addr = 32'h0, wr_data = 32'h0;
   logic [7:0] cmd_count = 8'h0;
   logic [3:0] cmd_lanes = 4'h0;
   logic cmd_ready, cmd_error, wr_ready, rd_valid, bus_read, bus_write;
   logic bus_waitrequest, bus_readdatavalid;
   logic [31:0] rd_data, bus_address, bus_writedata, bus_readdata;
   logic [7:0] bus_burstcount;
   logic [3:0] bus_byteenable;
   logic [3:0] bad_lanes [5] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h9};
   int fail_count = 0, compares = 0, i;
   always #50 clock = ~clock;
   mm_burst_master u_mm_burst_master (.clock(clock), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_lanes(cmd_lanes),
      .cmd_error(cmd_error), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
      .bus_address(bus_address), .bus_burstcount(bus_burstcount),
      .bus_byteenable(bus_byteenable), .bus_read(bus_read),
      .bus_write(bus_write), .bus_writedata(bus_writedata),
      .bus_waitrequest(bus_waitrequest), .bus_readdata(bus_readdata),
      .bus_readdatavalid(bus_readdatavalid));
   fabric_model u_fabric_model (.clock(clock), .arst_n(arst_n),
      .slow(slow), .bus_read(bus_read), .bus_burstcount(bus_burstcount),
      .bus_byteenable(bus_byteenable),
      .bus_waitrequest(bus_waitrequest), .bus_readdata(bus_readdata),
      .bus_readdatavalid(bus_readdatavalid));
   // ****************************************
   // Shared helpers
   // ****************************************
   task check(input logic [31:0] seen, input logic [31:0] expd);
      compares++;
      if (seen !== expd) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, expd);
      end
   endtask : check
   function automatic logic [31:0] mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : mask
   // One command, then every cycle of its burst is judged
   task run(input logic wr, input logic [31:0] addr, input logic [7:0] cnt,
            input logic [3:0] ln);
      logic [3:0] be;
      logic [31:0] exp_rd;
      logic take;
      int beats, n;
      be = (cnt > 8'h01) ? 4'hF : ln;
      beats = 0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr <= addr;
      cmd_count <= cnt;
      cmd_lanes <= ln;
      wr_valid <= wr;
      wr_data <= 32'hCAFE0000;
      @(posedge clock);
      cmd_valid <= 1'b0;
      for (n = 0; n < 80; n++) begin
         @(negedge clock);
         // Last read beat shows in the cycle the port turns idle again
         if (rd_valid === 1'b1) begin
            exp_rd = 32'h11223344 + beats * 32'h01010101;
            check(rd_data, exp_rd & mask(be));
            beats++;
         end
         if (cmd_ready === 1'b1) break;
         check(bus_address, addr & 32'hFFFFFFFC);
         check({24'h0, bus_burstcount}, {24'h0, cnt});
         check({28'h0, bus_byteenable}, {28'h0, be});
         if (bus_write === 1'b1 && bus_waitrequest === 1'b0) begin
            check(bus_writedata, 32'hCAFE0000 + beats);
            beats++;
         end
         take = (wr_ready === 1'b1);
         @(posedge clock);
         if (take) wr_data <= wr_data + 32'h1;
      end
      check({31'h0, cmd_ready}, 32'h1);
      check(32'(beats), {24'h0, cnt});
   endtask : run
   task reject(input logic [7:0] cnt, input logic [3:0] ln);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_write <= 1'b0;
      cmd_count <= cnt;
      cmd_lanes <= ln;
      wr_valid <= 1'b0;
      @(posedge clock);
      cmd_valid <= 1'b0;
      @(negedge clock);
      check({28'h0, cmd_error, cmd_ready, bus_read, bus_write}, 32'hC);
   endtask : reject
   task results;
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (5) @(negedge clock);
      check({26'h0, cmd_ready, cmd_error, wr_ready, rd_valid, bus_read,
             bus_write}, 32'h20);
      check({28'h0, bus_byteenable}, 32'h0);
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      check(32'($bits(bus_writedata)), 32'(8 * $bits(bus_byteenable)));
      run(1'b0, 32'h00001237, 8'h01, 4'hC);
      run(1'b0, 32'h00000040, 8'h01, 4'h8);
      @(posedge clock);
      slow <= 1'b1;
      // Burst ignores the narrow mask offered with it
      run(1'b0, 32'h00000103, 8'h04, 4'h1);
      run(1'b1, 32'h00000200, 8'h03, 4'h2);
      @(posedge clock);
      slow <= 1'b0;
      run(1'b1, 32'h0000000E, 8'h01, 4'h3);
      reject(8'h00, 4'hF);
      for (i = 0; i < 5; i++) reject(8'h01, bad_lanes[i]);
      run(1'b0, 32'h00000300, 8'h01, 4'hF);
      results;
   end
   initial begin
      #400000;
      fail_count++;
      results;
   end
endmodule : mm_burst_master_tb
`default_nettype wire
